// *** rtl/pss_selector.sv ***
// Notes on behaviour
// R1: high select alone commands the high preset, 60 Hz after reset.
// R2: middle select alone commands the middle preset, 30 Hz after reset.
// R3: low select alone commands the low preset, 10 Hz after reset.
// R4: several of high/middle/low together, with their speed 4 to 7 at 9999: the lowest speed asserted wins.
// R5: combinations of all four selects choose speeds 4 to 15.
// R6: speeds 4 to 15 reset to 9999, not selected, so start invalid.
// R7: speed 8 at 9999 with extended select alone commands the low preset.
// R8: extended select comes from any terminal set to function code 8.
// R9: low, middle, high follow terminals coded 0, 1, 2; default terminals 0-2.
// R10: source priority is jog, presets, analog terminal 4, analog terminal 2.
// R11: presets act only in operation mode 3 or 4.
// R12: nonzero remote function disables preset selection entirely.
// R13: analog compensation of the preset applies only when selection is 1.
// R14: preset writes are accepted in any mode, whatever the write selection.
// R15: presets 4 to 15 are writable only while user group read is 0.
// R16: presets 4 to 15 have no mutual priority; one combination, one preset.
// R17: presets hold 0 to 400 Hz, presets 4 to 15 also 9999; other writes are refused.
// R18: with extended select set, speed index is binary {x,h,m,l}, extended select weighted 8.
`timescale 1ns/1ps
module pss_selector #(
  parameter int NTERM = pss_pkg::NTERM
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register bus
  input pss_pkg::pss_apb_req_t apb_i,
  output pss_pkg::pss_apb_rsp_t apb_o,
  // contact input terminals
  input wire logic [NTERM-1:0] term_i,
  // other frequency sources
  input wire logic jog_i,
  input wire logic [15:0] jog_freq_i,
  input wire logic an4_valid_i,
  input wire logic [15:0] an4_freq_i,
  input wire logic an2_valid_i,
  input wire logic [15:0] an2_freq_i,
  input wire logic signed [15:0] comp_i,
  // frequency command
  output pss_pkg::pss_cmd_t cmd_o
);

  pss_pkg::pss_state_t st_ff;
  pss_pkg::pss_state_t nxt_st;

  logic sel_h;
  logic sel_m;
  logic sel_l;
  logic sel_x;
  logic [3:0] sel;
  logic [3:0] spd_raw;
  logic [3:0] spd_low;
  logic [3:0] spd_use;
  logic mode_ok;
  logic pres_ok;
  logic [15:0] pres_freq;
  logic signed [17:0] comp_sum;
  logic [15:0] comp_freq;
  pss_pkg::pss_cmd_t cmd_next;
  logic acc;
  logic is_preset;
  logic [3:0] pidx;
  logic [15:0] wval;
  logic range_ok;
  logic group_ok;
  logic hit;
  logic wr_ok;
  logic [31:0] rd_data;

  // select decode from synchronised terminals
  always_comb begin
    sel_h = 1'b0;
    sel_m = 1'b0;
    sel_l = 1'b0;
    sel_x = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      sel_l |= st_ff.sync2[i] && (st_ff.tfn[i] == pss_pkg::FN_LOW); // R9
      sel_m |= st_ff.sync2[i] && (st_ff.tfn[i] == pss_pkg::FN_MID); // R9
      sel_h |= st_ff.sync2[i] && (st_ff.tfn[i] == pss_pkg::FN_HIGH); // R9
      sel_x |= st_ff.sync2[i] && (st_ff.tfn[i] == pss_pkg::FN_EXT); // R8
    end
  end

  assign sel = {sel_x, sel_h, sel_m, sel_l};

  // speed number from the select pattern
  always_comb begin
    if (sel_x) begin
      spd_raw = sel; // R18 R5 R16
    end else begin
      unique case ({sel_h, sel_m, sel_l})
        3'b100: spd_raw = pss_pkg::SPD_HIGH; // R1
        3'b010: spd_raw = pss_pkg::SPD_MID; // R2
        3'b001: spd_raw = pss_pkg::SPD_LOW; // R3
        3'b110: spd_raw = 4'h4; // R5
        3'b101: spd_raw = 4'h5;
        3'b011: spd_raw = 4'h6;
        3'b111: spd_raw = 4'h7;
        default: spd_raw = pss_pkg::SPD_NONE;
      endcase
    end
  end

  // fallback when the chosen extended speed is not selected
  always_comb begin
    if (sel_l) begin
      spd_low = pss_pkg::SPD_LOW; // R4
    end else if (sel_m) begin
      spd_low = pss_pkg::SPD_MID; // R4
    end else if (sel_h) begin
      spd_low = pss_pkg::SPD_HIGH;
    end else begin
      spd_low = pss_pkg::SPD_LOW; // R7
    end
    if (spd_raw != pss_pkg::SPD_NONE && st_ff.preset[spd_raw] == pss_pkg::NOT_SEL) begin
      spd_use = spd_low; // R6
    end else begin
      spd_use = spd_raw;
    end
  end

  assign mode_ok = (st_ff.opm == pss_pkg::OPM_EXT) || (st_ff.opm == pss_pkg::OPM_COMB); // R11
  assign pres_ok = mode_ok && (st_ff.remote == 8'h00) && (spd_use != pss_pkg::SPD_NONE); // R12
  assign pres_freq = (spd_use == pss_pkg::SPD_NONE) ? 16'h0000 : st_ff.preset[spd_use];

  // compensation, clamped to the frequency range
  assign comp_sum = $signed({2'b00, pres_freq}) + 18'(comp_i);
  always_comb begin
    if (comp_sum < 18'sh00000) begin
      comp_freq = 16'h0000;
    end else if (comp_sum > $signed({2'b00, pss_pkg::FREQ_MAX})) begin
      comp_freq = pss_pkg::FREQ_MAX;
    end else begin
      comp_freq = comp_sum[15:0];
    end
  end

  // source arbitration
  always_comb begin
    cmd_next = '0;
    if (jog_i) begin
      cmd_next.valid = 1'b1; // R10
      cmd_next.src = pss_pkg::SRC_JOG;
      cmd_next.freq = jog_freq_i;
    end else if (pres_ok) begin
      cmd_next.valid = 1'b1; // R10
      cmd_next.src = pss_pkg::SRC_PRESET;
      cmd_next.freq = st_ff.comp ? comp_freq : pres_freq; // R13
    end else if (an4_valid_i) begin
      cmd_next.valid = 1'b1; // R10
      cmd_next.src = pss_pkg::SRC_AN4;
      cmd_next.freq = an4_freq_i;
    end else if (an2_valid_i) begin
      cmd_next.valid = 1'b1;
      cmd_next.src = pss_pkg::SRC_AN2;
      cmd_next.freq = an2_freq_i;
    end else begin
      cmd_next.src = pss_pkg::SRC_NONE;
    end
  end

  // bus decode
  assign acc = apb_i.psel && apb_i.penable && !st_ff.rsp.pready;
  assign is_preset = (apb_i.paddr[11:6] == pss_pkg::ADDR_PRESET[11:6])
    && (apb_i.paddr[5:2] != 4'h0) && (apb_i.paddr[1:0] == 2'b00);
  assign pidx = apb_i.paddr[5:2];
  assign wval = apb_i.pwdata[15:0];
  assign range_ok = (apb_i.pwdata[31:16] == 16'h0000) && ((wval <= pss_pkg::FREQ_MAX)
    || (pidx >= pss_pkg::SPD_FIRST_EXT && wval == pss_pkg::NOT_SEL)); // R17
  assign group_ok = (pidx < pss_pkg::SPD_FIRST_EXT) || (st_ff.ugrp == pss_pkg::UGRP_ALL); // R15

  always_comb begin
    hit = 1'b0;
    rd_data = 32'h0000_0000;
    if (is_preset) begin
      hit = 1'b1;
      rd_data = {16'h0000, st_ff.preset[pidx]};
    end
    if (apb_i.paddr == pss_pkg::ADDR_CFG) begin
      hit = 1'b1;
      rd_data[pss_pkg::CFG_OPM_LSB +: 8] = st_ff.opm;
      rd_data[pss_pkg::CFG_REM_LSB +: 8] = st_ff.remote;
      rd_data[pss_pkg::CFG_COMP_BIT] = st_ff.comp;
      rd_data[pss_pkg::CFG_PWR_LSB +: 2] = st_ff.pwr;
    end
    if (apb_i.paddr == pss_pkg::ADDR_UGRP) begin
      hit = 1'b1;
      rd_data = {16'h0000, st_ff.ugrp};
    end
    for (int w = 0; w < pss_pkg::TFN_WORDS; w++) begin
      if (apb_i.paddr == pss_pkg::ADDR_TFN0 + 12'(4 * w)) begin
        hit = 1'b1;
        for (int i = 0; i < pss_pkg::TFN_PER_WORD; i++) begin
          rd_data[8*i +: 8] = st_ff.tfn[pss_pkg::TFN_PER_WORD*w + i];
        end
      end
    end
    if (apb_i.paddr == pss_pkg::ADDR_STATUS) begin
      hit = 1'b1;
      rd_data[pss_pkg::ST_FREQ_LSB +: 16] = st_ff.cmd.freq;
      rd_data[pss_pkg::ST_SPD_LSB +: 4] = st_ff.spd;
      rd_data[pss_pkg::ST_SRC_LSB +: 3] = st_ff.cmd.src;
      rd_data[pss_pkg::ST_VALID_BIT] = st_ff.cmd.valid;
      rd_data[pss_pkg::ST_SEL_LSB +: 4] = sel;
    end
  end

  // preset writes ignore the write selection field
  assign wr_ok = !is_preset || (range_ok && group_ok); // R14

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = term_i;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.rsp.pready = 1'b0;
    nxt_st.rsp.pslverr = 1'b0;
    if (acc) begin
      nxt_st.rsp.pready = 1'b1;
      nxt_st.rsp.prdata = apb_i.pwrite ? 32'h0000_0000 : rd_data;
      nxt_st.rsp.pslverr = !hit || (apb_i.pwrite && !wr_ok); // R17 R15
      if (apb_i.pwrite && hit && wr_ok) begin
        if (is_preset) begin
          nxt_st.preset[pidx] = wval; // R14
        end
        if (apb_i.paddr == pss_pkg::ADDR_CFG) begin
          nxt_st.opm = apb_i.pwdata[pss_pkg::CFG_OPM_LSB +: 8];
          nxt_st.remote = apb_i.pwdata[pss_pkg::CFG_REM_LSB +: 8];
          nxt_st.comp = apb_i.pwdata[pss_pkg::CFG_COMP_BIT];
          nxt_st.pwr = apb_i.pwdata[pss_pkg::CFG_PWR_LSB +: 2];
        end
        if (apb_i.paddr == pss_pkg::ADDR_UGRP) begin
          nxt_st.ugrp = apb_i.pwdata[15:0];
        end
        for (int w = 0; w < pss_pkg::TFN_WORDS; w++) begin
          if (apb_i.paddr == pss_pkg::ADDR_TFN0 + 12'(4 * w)) begin
            for (int i = 0; i < pss_pkg::TFN_PER_WORD; i++) begin
              nxt_st.tfn[pss_pkg::TFN_PER_WORD*w + i] = apb_i.pwdata[8*i +: 8];
            end
          end
        end
      end
    end
    nxt_st.cmd = cmd_next;
    nxt_st.spd = (pres_ok && !jog_i) ? spd_use : pss_pkg::SPD_NONE;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_ff <= pss_pkg::pss_reset_state(); // R6
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign apb_o = st_ff.rsp;
  assign cmd_o = st_ff.cmd;

  a_high_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R1
    (!jog_i && pres_ok && sel == 4'b0100 && !st_ff.comp)
    |=> (cmd_o.src == pss_pkg::SRC_PRESET) && (cmd_o.freq == $past(st_ff.preset[1])))
    else $error("high select did not command the high preset");

  a_mid_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R2
    (!jog_i && pres_ok && sel == 4'b0010 && !st_ff.comp)
    |=> cmd_o.freq == $past(st_ff.preset[2]))
    else $error("middle select did not command the middle preset");

  a_low_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R3
    (!jog_i && pres_ok && sel == 4'b0001 && !st_ff.comp)
    |=> cmd_o.freq == $past(st_ff.preset[3]))
    else $error("low select did not command the low preset");

  a_lowest_wins: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R4
    (!jog_i && pres_ok && sel == 4'b0110 && st_ff.preset[4] == pss_pkg::NOT_SEL
     && !st_ff.comp)
    |=> cmd_o.freq == $past(st_ff.preset[2]))
    else $error("high plus middle did not fall to the middle preset");

  a_ext_fallback: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
    (!jog_i && pres_ok && sel == 4'b1000 && st_ff.preset[8] == pss_pkg::NOT_SEL
     && !st_ff.comp)
    ##1 1'b1 |-> cmd_o.freq == $past(st_ff.preset[3]) && st_ff.spd == pss_pkg::SPD_LOW)
    else $error("extended alone with speed 8 unset did not use the low preset");

  a_jog_first: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
    jog_i |=> (cmd_o.src == pss_pkg::SRC_JOG) && (cmd_o.freq == $past(jog_freq_i)))
    else $error("jog did not take priority");

  a_mode_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11 R12
    (!mode_ok || st_ff.remote != 8'h00) |=> cmd_o.src != pss_pkg::SRC_PRESET)
    else $error("preset selected outside its operation mode");

  a_range_reject: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R17
    (acc && apb_i.pwrite && is_preset && !range_ok)
    |=> apb_o.pready && apb_o.pslverr
        && st_ff.preset[$past(pidx)] == $past(st_ff.preset[pidx]))
    else $error("out of range preset write was not refused");

  a_group_lock: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R15
    (acc && apb_i.pwrite && is_preset && pidx >= pss_pkg::SPD_FIRST_EXT
     && st_ff.ugrp != pss_pkg::UGRP_ALL)
    |=> st_ff.preset[$past(pidx)] == $past(st_ff.preset[pidx]))
    else $error("extended preset written while user group locked");

  a_preset_store: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R14
    (acc && apb_i.pwrite && is_preset && range_ok && group_ok)
    |=> !apb_o.pslverr && (st_ff.preset[$past(pidx)] == $past(wval)))
    else $error("legal preset write was not stored");

  a_ext_binary: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R5
    (!jog_i && pres_ok && sel_x && st_ff.preset[sel] != pss_pkg::NOT_SEL && !st_ff.comp)
    |=> (st_ff.spd == $past(sel)) && (cmd_o.freq == $past(st_ff.preset[sel])))
    else $error("extended combination did not choose its own preset");

  a_unset_skip: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R6
    (!jog_i && pres_ok && sel_x && st_ff.preset[sel] == pss_pkg::NOT_SEL)
    |=> st_ff.spd != $past(sel))
    else $error("unset extended speed was commanded");

  a_no_comp: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
    (!jog_i && pres_ok && !st_ff.comp)
    |=> (cmd_o.src == pss_pkg::SRC_PRESET) && (cmd_o.freq == $past(pres_freq)))
    else $error("preset compensated while compensation is off");

  a_comp_clamp: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
    (!jog_i && pres_ok && st_ff.comp)
    |=> (cmd_o.src == pss_pkg::SRC_PRESET) && (cmd_o.freq <= pss_pkg::FREQ_MAX))
    else $error("compensated preset left the frequency range");

  a_an4_next: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
    (!jog_i && !pres_ok && an4_valid_i)
    |=> (cmd_o.src == pss_pkg::SRC_AN4) && (cmd_o.freq == $past(an4_freq_i)))
    else $error("analog terminal 4 did not follow the presets");

  a_an2_last: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
    (!jog_i && !pres_ok && !an4_valid_i && an2_valid_i)
    |=> (cmd_o.src == pss_pkg::SRC_AN2) && (cmd_o.freq == $past(an2_freq_i)))
    else $error("analog terminal 2 did not come last");

  a_idle_none: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
    (!jog_i && !pres_ok && !an4_valid_i && !an2_valid_i)
    |=> !cmd_o.valid && (cmd_o.src == pss_pkg::SRC_NONE))
    else $error("command present with no source");

endmodule : pss_selector

// *** rtl/pss_pkg.sv ***
package pss_pkg;

  // widths
  localparam int NTERM = 12;
  localparam int FW = 16;

  // frequencies in 0.1 Hz steps
  localparam logic [15:0] FREQ_MAX = 16'h0FA0;
  localparam logic [15:0] NOT_SEL = 16'h270F;
  localparam logic [15:0] HIGH_INIT = 16'h0258;
  localparam logic [15:0] MID_INIT = 16'h012C;
  localparam logic [15:0] LOW_INIT = 16'h0064;

  // speed numbers
  localparam logic [3:0] SPD_NONE = 4'h0;
  localparam logic [3:0] SPD_HIGH = 4'h1;
  localparam logic [3:0] SPD_MID = 4'h2;
  localparam logic [3:0] SPD_LOW = 4'h3;
  localparam logic [3:0] SPD_FIRST_EXT = 4'h4;
  localparam logic [3:0] SPD_8 = 4'h8;

  // input terminal function codes
  localparam logic [7:0] FN_LOW = 8'h00;
  localparam logic [7:0] FN_MID = 8'h01;
  localparam logic [7:0] FN_HIGH = 8'h02;
  localparam logic [7:0] FN_EXT = 8'h08;
  localparam logic [7:0] FN_NONE = 8'hFF;

  // operation modes and defaults
  localparam logic [7:0] OPM_EXT = 8'h03;
  localparam logic [7:0] OPM_COMB = 8'h04;
  localparam logic [7:0] OPM_INIT = 8'h00;
  localparam logic [15:0] UGRP_ALL = 16'h0000;

  // register byte addresses
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_UGRP = 12'h004;
  localparam logic [11:0] ADDR_TFN0 = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_PRESET = 12'h040;
  localparam int TFN_WORDS = 3;
  localparam int TFN_PER_WORD = 4;

  // config word fields
  localparam int CFG_OPM_LSB = 0;
  localparam int CFG_REM_LSB = 8;
  localparam int CFG_COMP_BIT = 16;
  localparam int CFG_PWR_LSB = 17;

  // status word fields
  localparam int ST_FREQ_LSB = 0;
  localparam int ST_SPD_LSB = 16;
  localparam int ST_SRC_LSB = 20;
  localparam int ST_VALID_BIT = 23;
  localparam int ST_SEL_LSB = 24;

  // frequency source
  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_JOG = 3'h1,
    SRC_PRESET = 3'h3,
    SRC_AN4 = 3'h2,
    SRC_AN2 = 3'h6
  } pss_src_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pss_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pss_apb_rsp_t;

  typedef struct packed {
    logic valid;
    pss_src_t src;
    logic [15:0] freq;
  } pss_cmd_t;

  typedef struct packed {
    logic [NTERM-1:0] sync1;
    logic [NTERM-1:0] sync2;
    logic [7:0] opm;
    logic [7:0] remote;
    logic comp;
    logic [1:0] pwr;
    logic [15:0] ugrp;
    logic [NTERM-1:0][7:0] tfn;
    logic [15:1][15:0] preset;
    logic [3:0] spd;
    pss_apb_rsp_t rsp;
    pss_cmd_t cmd;
  } pss_state_t;

  function automatic pss_state_t pss_reset_state();
    pss_state_t s;
    s = '0;
    s.opm = OPM_INIT;
    s.ugrp = UGRP_ALL;
    for (int i = 0; i < NTERM; i++) begin
      s.tfn[i] = FN_NONE;
    end
    s.tfn[0] = FN_LOW;
    s.tfn[1] = FN_MID;
    s.tfn[2] = FN_HIGH;
    for (int k = 4; k < 16; k++) begin
      s.preset[k] = NOT_SEL;
    end
    s.preset[1] = HIGH_INIT;
    s.preset[2] = MID_INIT;
    s.preset[3] = LOW_INIT;
    s.cmd.src = SRC_NONE;
    return s;
  endfunction : pss_reset_state

endpackage : pss_pkg

// *** tb/pss_contacts.sv ***
`timescale 1ns/1ps
module pss_contacts (
  // clock
  input wire logic mclk_i,
  // requested selects {x,h,m,l} and terminal routing
  input wire logic [3:0] sel_i,
  input wire logic alt_i,
  // contact terminals
  output logic [11:0] term_o
);
  // open contacts read as off; alt moves the selects to terminals 4 to 7
  always_ff @(posedge mclk_i) begin
    term_o <= alt_i ? {4'h0, sel_i, 4'h0} : {8'h00, sel_i};
  end
endmodule : pss_contacts

// *** tb/test_pss_selector.sv ***
`timescale 1ns/1ps
module test_pss_selector;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  pss_pkg::pss_apb_req_t apb_i = '0;
  pss_pkg::pss_apb_rsp_t apb_o;
  pss_pkg::pss_cmd_t cmd_o;
  logic [11:0] term_i;
  logic [3:0] sel = 4'h0;
  logic alt = 1'b0;
  logic jog_i = 1'b0;
  logic an4_valid_i = 1'b0;
  logic an2_valid_i = 1'b0;
  logic signed [15:0] comp_i = 16'sh0000;
  int mismatches = 0;
  int n_tests = 0;
  logic [31:0] rdv;
  logic errv;
  logic [3:0] ts [6] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8};
  logic [15:0] tf [6] = '{16'h0064, 16'h012C, 16'h0258, 16'h012C, 16'h0064, 16'h0064};

  always #2 mclk_i = ~mclk_i;

  pss_contacts u_sw (.mclk_i(mclk_i), .sel_i(sel), .alt_i(alt), .term_o(term_i));

  pss_selector DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .apb_o(apb_o),
    .term_i(term_i), .jog_i(jog_i), .jog_freq_i(16'h0032),
    .an4_valid_i(an4_valid_i), .an4_freq_i(16'h01F4),
    .an2_valid_i(an2_valid_i), .an2_freq_i(16'h00FA),
    .comp_i(comp_i), .cmd_o(cmd_o)
  );

  function automatic pss_pkg::pss_cmd_t cm(input pss_pkg::pss_src_t s, input logic [15:0] f);
    cm = '{1'b1, s, f};
  endfunction : cm

  function automatic logic [11:0] pa(input int k);
    pa = pss_pkg::ADDR_PRESET + 12'(4 * k);
  endfunction : pa

  task complete_run();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task chk_word(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_word

  task chk_cmd(input pss_pkg::pss_cmd_t e);
    repeat (6) @(posedge mclk_i);
    #1;
    n_tests++;
    if (cmd_o !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cmd_o, e);
    end
  endtask : chk_cmd

  // drive selects and side sources together, then check the command
  task go(input logic [3:0] s, input logic j, input logic a4, input logic a2,
          input pss_pkg::pss_cmd_t e);
    @(posedge mclk_i);
    sel <= s;
    jog_i <= j;
    an4_valid_i <= a4;
    an2_valid_i <= a2;
    chk_cmd(e);
  endtask : go

  // waits for pready without a cycle limit; only the watchdog ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk_i);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (apb_o.pready !== 1'b1);
    rdv = apb_o.prdata;
    errv = apb_o.pslverr;
    apb_i <= '0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk_word({31'h0, errv}, {31'h0, e});
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_word(rdv, e);
  endtask : rd

  initial begin
    #80000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(pss_pkg::ADDR_CFG, 32'h0);
    rd(pa(1), 32'h00000258);
    rd(pa(8), 32'h0000270F);
    rd(pss_pkg::ADDR_TFN0, 32'hFF020100);
    rd(pss_pkg::ADDR_TFN0 + 12'h008, 32'hFFFFFFFF);
    go(4'h1, 1'b0, 1'b0, 1'b0, '0);
    wr(pss_pkg::ADDR_CFG, 32'h00000003, 1'b0);
    wr(pss_pkg::ADDR_TFN0, 32'h08020100, 1'b0);
    for (int i = 0; i < 6; i++) begin
      go(ts[i], 1'b0, 1'b0, 1'b0, cm(pss_pkg::SRC_PRESET, tf[i]));
    end
    go(4'hF, 1'b0, 1'b0, 1'b0, cm(pss_pkg::SRC_PRESET, 16'h0064));
    wr(pa(8), 32'h000004D2, 1'b0);
    go(4'h8, 1'b0, 1'b0, 1'b0, cm(pss_pkg::SRC_PRESET, 16'h04D2));
    wr(pa(15), 32'h00000FA0, 1'b0);
    wr(pa(9), 32'h00000005, 1'b0);
    go(4'hF, 1'b0, 1'b0, 1'b0, cm(pss_pkg::SRC_PRESET, 16'h0FA0));
    go(4'h9, 1'b0, 1'b0, 1'b0, cm(pss_pkg::SRC_PRESET, 16'h0005));
    wr(pss_pkg::ADDR_CFG, 32'h00000004, 1'b0);
    go(4'h1, 1'b0, 1'b0, 1'b0, cm(pss_pkg::SRC_PRESET, 16'h0064));
    @(posedge mclk_i);
    comp_i <= 16'sh0032;
    chk_cmd(cm(pss_pkg::SRC_PRESET, 16'h0064));
    wr(pss_pkg::ADDR_CFG, 32'h00010004, 1'b0);
    chk_cmd(cm(pss_pkg::SRC_PRESET, 16'h0096));
    @(posedge mclk_i);
    comp_i <= -16'sd200;
    chk_cmd(cm(pss_pkg::SRC_PRESET, 16'h0000));
    @(posedge mclk_i);
    comp_i <= 16'sh0000;
    wr(pss_pkg::ADDR_CFG, 32'h00000004, 1'b0);
    go(4'h1, 1'b1, 1'b1, 1'b1, cm(pss_pkg::SRC_JOG, 16'h0032));
    go(4'h1, 1'b0, 1'b1, 1'b1, cm(pss_pkg::SRC_PRESET, 16'h0064));
    go(4'h0, 1'b0, 1'b1, 1'b1, cm(pss_pkg::SRC_AN4, 16'h01F4));
    go(4'h0, 1'b0, 1'b0, 1'b1, cm(pss_pkg::SRC_AN2, 16'h00FA));
    wr(pss_pkg::ADDR_CFG, 32'h00000104, 1'b0);
    go(4'h1, 1'b0, 1'b0, 1'b0, '0);
    go(4'h1, 1'b0, 1'b1, 1'b0, cm(pss_pkg::SRC_AN4, 16'h01F4));
    wr(pss_pkg::ADDR_CFG, 32'h00000004, 1'b0);
    wr(pa(1), 32'h00000FA1, 1'b1);
    wr(pa(1), 32'h0000270F, 1'b1);
    wr(pa(4), 32'h00000FA1, 1'b1);
    rd(pa(1), 32'h00000258);
    wr(pss_pkg::ADDR_UGRP, 32'h00000001, 1'b0);
    wr(pa(9), 32'h00000064, 1'b1);
    wr(pa(2), 32'h000000C8, 1'b0);
    rd(pa(9), 32'h00000005);
    rd(pa(2), 32'h000000C8);
    wr(pss_pkg::ADDR_PRESET, 32'h00000001, 1'b1);
    wr(pss_pkg::ADDR_TFN0, 32'h08FF0100, 1'b0);
    wr(pss_pkg::ADDR_TFN0 + 12'h004, 32'hFF02FFFF, 1'b0);
    alt <= 1'b1;
    go(4'h4, 1'b0, 1'b0, 1'b0, cm(pss_pkg::SRC_PRESET, 16'h0258));
    rd(pss_pkg::ADDR_STATUS, 32'h04B10258);
    complete_run();
  end
endmodule : test_pss_selector
